// ---- dej_pkg.sv ----
// shared constants, opcode patterns and carrier structs for the decrement/extend/jump unit
package dej_pkg;

  localparam int XLEN = 32;
  localparam int RIDX = 4;

  // opcode layout: [15:12] group, [11:8] dest, [7:4] source, [3:0] minor
  localparam int OP_GRP_HI = 15;
  localparam int OP_GRP_LO = 12;
  localparam int OP_N_HI = 11;
  localparam int OP_N_LO = 8;
  localparam int OP_M_HI = 7;
  localparam int OP_M_LO = 4;
  localparam int OP_MIN_HI = 3;
  localparam int OP_MIN_LO = 0;
  localparam int OP_LOW_HI = 7;

  localparam logic [3:0] GRP_SYS = 4'h4;
  localparam logic [3:0] GRP_MOVE = 4'h6;
  localparam logic [7:0] LOW_DECR = 8'h10;
  localparam logic [7:0] LOW_JUMP = 8'h2b;
  localparam logic [7:0] LOW_CALL = 8'h0b;
  localparam logic [3:0] MIN_ZXB = 4'hc;
  localparam logic [3:0] MIN_ZXW = 4'hd;
  localparam logic [3:0] MIN_SXB = 4'he;
  localparam logic [3:0] MIN_SXW = 4'hf;

  // field positions used by the extensions
  localparam int BYTE_MSB = 7;
  localparam int HALF_MSB = 15;

  // link holds the address of the second instruction after the call
  localparam logic [XLEN-1:0] LINK_OFFSET = 32'h0000_0004;
  localparam logic [XLEN-1:0] DECR_STEP = 32'h0000_0001;
  localparam logic [XLEN-1:0] ZERO_WORD = 32'h0000_0000;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_DECR,
    OP_SXB,
    OP_SXW,
    OP_ZXB,
    OP_ZXW,
    OP_JUMP,
    OP_CALL
  } op_kind_e;

  // one instruction handed over by the decode stage
  typedef struct packed {
    logic [15:0] opcode;
    logic [XLEN-1:0] pc;
    logic other_branch;
  } instr_s;

  // general register write-back
  typedef struct packed {
    logic we;
    logic [RIDX-1:0] addr;
    logic [XLEN-1:0] data;
  } gpr_wr_s;

  // zero flag write
  typedef struct packed {
    logic we;
    logic val;
  } flag_wr_s;

  // program counter redirect and link write
  typedef struct packed {
    logic taken;
    logic [XLEN-1:0] target;
    logic link_we;
    logic [XLEN-1:0] link_data;
  } branch_s;

endpackage

// ---- dej_decode.sv ----
// opcode classifier for the decrement/extend/jump unit
module dej_decode
  import dej_pkg::*;
(
  // opcode in
  input wire logic [15:0] opcode,
  // classification out
  output op_kind_e kind,
  output logic [RIDX-1:0] dest_gpr,
  output logic [RIDX-1:0] src_gpr
);

  wire [3:0] grp = opcode[OP_GRP_HI:OP_GRP_LO];
  wire [7:0] low = opcode[OP_LOW_HI:OP_MIN_LO];
  wire [3:0] minor = opcode[OP_MIN_HI:OP_MIN_LO];
  wire is_sys = (grp == GRP_SYS);
  wire is_move = (grp == GRP_MOVE);

  assign dest_gpr = opcode[OP_N_HI:OP_N_LO];
  assign src_gpr = opcode[OP_M_HI:OP_M_LO];

  // fixed patterns; anything else is not ours
  assign kind = (is_sys && low == LOW_DECR) ? OP_DECR :
                (is_sys && low == LOW_JUMP) ? OP_JUMP :
                (is_sys && low == LOW_CALL) ? OP_CALL :
                (is_move && minor == MIN_SXB) ? OP_SXB :
                (is_move && minor == MIN_SXW) ? OP_SXW :
                (is_move && minor == MIN_ZXB) ? OP_ZXB :
                (is_move && minor == MIN_ZXW) ? OP_ZXW : OP_NONE;

endmodule

// ---- dej_exec.sv ----
// execution unit for decrement-and-test, extensions and register-indirect delayed branches
// Notes on behaviour
// - decrement-and-test subtracts one from dest_gpr and writes it back there.
// - decrement-and-test sets zero flag when new value is zero, else clears it.
// - byte sign extension copies bit 7 into bits 8 to 31.
// - word sign extension copies bit 15 into bits 16 to 31.
// - both sign extensions finish in one execution state.
// - byte zero extension keeps low byte and clears bits 8 to 31.
// - word zero extension keeps low halfword and clears bits 16 to 31.
// - both zero extensions finish in one execution state.
// - indirect jump 0100nnnn00101011 takes two states, jumps to register address.
// - the one instruction after jump or call runs before the transfer.
// - no interrupt or address error accepted between branch and its slot.
// - a branch sitting in a delay slot is reported as illegal slot.
// - target is the register value before the slot instruction runs.
// - subroutine call 0100nnnn00001011 takes two states, jumps to register address.
// - call loads link_register with address of second instruction after it.
module dej_exec
  import dej_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // instruction from decode stage
  input wire logic in_valid,
  output logic in_ready,
  input wire instr_s in_instr,
  // general register file read ports, data valid in the same cycle
  output logic [RIDX-1:0] rd_addr_n,
  output logic [RIDX-1:0] rd_addr_m,
  input wire logic [XLEN-1:0] rd_data_n,
  input wire logic [XLEN-1:0] rd_data_m,
  // results
  output gpr_wr_s gpr_wr,
  output flag_wr_s flag_wr,
  output branch_s branch,
  // exception control
  output logic event_block,
  output logic illegal_slot
);

  typedef enum logic [1:0] {
    ST_RUN,
    ST_BR2,
    ST_SLOT
  } exec_state_e;

  op_kind_e kind;
  logic [RIDX-1:0] dest_gpr;
  logic [RIDX-1:0] src_gpr;

  dej_decode u_dec (
    .opcode(in_instr.opcode),
    .kind(kind),
    .dest_gpr(dest_gpr),
    .src_gpr(src_gpr)
  );

  exec_state_e state_q, state_d;
  logic [XLEN-1:0] target_q, target_d;
  gpr_wr_s gpr_q, gpr_d;
  flag_wr_s flag_q, flag_d;
  branch_s br_q, br_d;
  logic illegal_q, illegal_d;

  // sign extension of a field whose top bit sits at msb
  function automatic logic [XLEN-1:0] sext(input logic [XLEN-1:0] v, input int msb);
    logic [XLEN-1:0] r;
    r = v;
    for (int i = 0; i < XLEN; i++) begin
      if (i > msb) begin
        r[i] = v[msb];
      end
    end
    return r;
  endfunction

  // zero extension of a field whose top bit sits at msb
  function automatic logic [XLEN-1:0] zext(input logic [XLEN-1:0] v, input int msb);
    logic [XLEN-1:0] r;
    r = v;
    for (int i = 0; i < XLEN; i++) begin
      if (i > msb) begin
        r[i] = 1'b0;
      end
    end
    return r;
  endfunction

  // operand selection and results, all combinational from the offered instruction, the read ports and state_q
  wire take = in_valid && in_ready;
  wire is_branch = (kind == OP_JUMP) || (kind == OP_CALL);
  wire in_slot = (state_q == ST_SLOT);
  wire slot_bad = in_slot && (is_branch || in_instr.other_branch);
  wire [XLEN-1:0] decr_val = rd_data_n - DECR_STEP;
  wire [XLEN-1:0] link_val = in_instr.pc + LINK_OFFSET;

  assign rd_addr_n = dest_gpr;
  assign rd_addr_m = src_gpr;
  // second branch state holds the pipeline for one cycle
  assign in_ready = (state_q != ST_BR2);
  // interrupts and address errors are held off from branch through slot
  assign event_block = (state_q != ST_RUN);

  // next-state and result logic
  always_comb begin
    state_d = state_q;
    target_d = target_q;
    gpr_d = '0;
    flag_d = '0;
    br_d = '0;
    illegal_d = 1'b0;
    case (state_q)
      ST_RUN: begin
        if (take) begin
          gpr_d.addr = dest_gpr;
          case (kind)
            OP_DECR: begin
              gpr_d.we = 1'b1;
              gpr_d.data = decr_val;
              flag_d.we = 1'b1;
              flag_d.val = (decr_val == ZERO_WORD);
            end
            OP_SXB: begin
              gpr_d.we = 1'b1;
              gpr_d.data = sext(rd_data_m, BYTE_MSB);
            end
            OP_SXW: begin
              gpr_d.we = 1'b1;
              gpr_d.data = sext(rd_data_m, HALF_MSB);
            end
            OP_ZXB: begin
              gpr_d.we = 1'b1;
              gpr_d.data = zext(rd_data_m, BYTE_MSB);
            end
            OP_ZXW: begin
              gpr_d.we = 1'b1;
              gpr_d.data = zext(rd_data_m, HALF_MSB);
            end
            OP_JUMP: begin
              target_d = rd_data_n;
              state_d = ST_BR2;
            end
            OP_CALL: begin
              target_d = rd_data_n;
              br_d.link_we = 1'b1;
              br_d.link_data = link_val;
              state_d = ST_BR2;
            end
            default: begin
              gpr_d.we = 1'b0;
            end
          endcase
        end
      end
      ST_BR2: begin
        state_d = ST_SLOT;
      end
      ST_SLOT: begin
        if (take) begin
          // redirect leaves together with the slot result
          br_d.taken = 1'b1;
          br_d.target = target_q;
          state_d = ST_RUN;
          if (slot_bad) begin
            illegal_d = 1'b1;
          end else begin
            gpr_d.addr = dest_gpr;
            case (kind)
              OP_DECR: begin
                gpr_d.we = 1'b1;
                gpr_d.data = decr_val;
                flag_d.we = 1'b1;
                flag_d.val = (decr_val == ZERO_WORD);
              end
              OP_SXB: begin
                gpr_d.we = 1'b1;
                gpr_d.data = sext(rd_data_m, BYTE_MSB);
              end
              OP_SXW: begin
                gpr_d.we = 1'b1;
                gpr_d.data = sext(rd_data_m, HALF_MSB);
              end
              OP_ZXB: begin
                gpr_d.we = 1'b1;
                gpr_d.data = zext(rd_data_m, BYTE_MSB);
              end
              OP_ZXW: begin
                gpr_d.we = 1'b1;
                gpr_d.data = zext(rd_data_m, HALF_MSB);
              end
              default: begin
                gpr_d.we = 1'b0;
              end
            endcase
          end
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // state and registered outputs
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_RUN;
      target_q <= '0;
      gpr_q <= '0;
      flag_q <= '0;
      br_q <= '0;
      illegal_q <= 1'b0;
    end else begin
      state_q <= state_d;
      target_q <= target_d;
      gpr_q <= gpr_d;
      flag_q <= flag_d;
      br_q <= br_d;
      illegal_q <= illegal_d;
    end
  end

  assign gpr_wr = gpr_q;
  assign flag_wr = flag_q;
  assign branch = br_q;
  assign illegal_slot = illegal_q;

endmodule

// ---- dej_chk.sv ----
// port assertions for the decrement/extend/jump unit
module dej_chk
  import dej_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // request side
  input wire logic in_valid,
  input wire logic in_ready,
  input wire instr_s in_instr,
  input wire logic [XLEN-1:0] rd_data_n,
  input wire logic [XLEN-1:0] rd_data_m,
  // results
  input wire gpr_wr_s gpr_wr,
  input wire flag_wr_s flag_wr,
  input wire branch_s branch,
  input wire logic event_block,
  input wire logic illegal_slot
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // taken requests by class; flagged branches are left out
  wire logic [15:0] op = in_instr.opcode;
  wire logic tk = in_valid && in_ready;
  wire logic ok = tk && !in_instr.other_branch;
  wire logic dt = ok && op[15:12] == GRP_SYS && op[7:0] == LOW_DECR;
  wire logic ex = ok && op[15:12] == GRP_MOVE;
  // a branch offered in a slot is refused, so it does not start a new branch window
  wire logic br = ok && !event_block && op[15:12] == GRP_SYS
    && (op[7:0] == LOW_JUMP || op[7:0] == LOW_CALL);
  wire logic [XLEN-1:0] m = rd_data_m;
  dt_write_a: assert property (dt |=> gpr_wr.we && gpr_wr.addr == $past(op[11:8])
    && gpr_wr.data == $past(rd_data_n) - 32'h1) else $error("decrement result wrong");
  dt_flag_a: assert property (dt |=> flag_wr.we && flag_wr.val == ($past(rd_data_n) == 32'h1))
    else $error("decrement flag wrong");
  sx_byte_a: assert property (ex && op[3:0] == MIN_SXB |=> gpr_wr.we
    && gpr_wr.data == {{24{$past(m[7])}}, $past(m[7:0])}) else $error("byte sign extend wrong");
  sx_word_a: assert property (ex && op[3:0] == MIN_SXW |=> gpr_wr.we
    && gpr_wr.data == {{16{$past(m[15])}}, $past(m[15:0])}) else $error("word sign extend wrong");
  zx_ext_a: assert property (ex && op[3:1] == 3'h6 |=> gpr_wr.we && gpr_wr.data ==
    ($past(op[0]) ? {16'h0, $past(m[15:0])} : {24'h0, $past(m[7:0])})) else $error("zero extend wrong");
  branch_stall_a: assert property (br |=> !in_ready ##1 in_ready)
    else $error("branch did not take two states");
  hold_off_a: assert property (br |=> event_block [*2])
    else $error("events not held off after branch");
  slot_target_a: assert property (br ##2 tk |=> branch.taken
    && branch.target == $past(rd_data_n, 3)) else $error("redirect after slot wrong");
  slot_illegal_a: assert property (br ##2 (tk && in_instr.other_branch) |=> illegal_slot
    && !gpr_wr.we) else $error("branch in slot not refused");
  flag_owner_a: assert property (flag_wr.we |-> $past(dt))
    else $error("flag written by other instruction");
endmodule
bind dej_exec dej_chk u_chk (.sys_clk, .nrst, .in_valid, .in_ready, .in_instr, .rd_data_n,
  .rd_data_m, .gpr_wr, .flag_wr, .branch, .event_block, .illegal_slot);

// ---- gpr_model.sv ----
// behavioural general register file behind the unit
module gpr_model
  import dej_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // read ports
  input wire logic [RIDX-1:0] rd_addr_n,
  input wire logic [RIDX-1:0] rd_addr_m,
  output logic [XLEN-1:0] rd_data_n,
  output logic [XLEN-1:0] rd_data_m,
  // write-back
  input wire gpr_wr_s gpr_wr,
  // bench preload, applied after the write-back so it wins on a shared edge
  input wire logic pre_we,
  input wire logic [RIDX-1:0] pre_addr,
  input wire logic [XLEN-1:0] pre_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [XLEN-1:0] regs [16];
  // reads are combinational so operands meet the same-cycle contract
  assign rd_data_n = regs[rd_addr_n];
  assign rd_data_m = regs[rd_addr_m];
  // a write lands at the edge that ends its result cycle
  always @(posedge sys_clk) begin
    if (gpr_wr.we) begin
      regs[gpr_wr.addr] <= gpr_wr.data;
    end
    if (pre_we) begin
      regs[pre_addr] <= pre_data;
    end
  end
endmodule

// ---- dej_exec_tb.sv ----
// self-checking bench for the decrement/extend/jump unit
module dej_exec_tb
  import dej_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic in_valid = 1'b0;
  logic pre_we = 1'b0;
  logic [RIDX-1:0] pre_addr = '0;
  logic [XLEN-1:0] pre_data = '0;
  instr_s in_instr = '0;
  logic in_ready, event_block, illegal_slot;
  logic [RIDX-1:0] rd_addr_n, rd_addr_m;
  logic [XLEN-1:0] rd_data_n, rd_data_m;
  gpr_wr_s gpr_wr;
  flag_wr_s flag_wr;
  branch_s branch;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #20 sys_clk = ~sys_clk;
  dej_exec u_dut (.sys_clk, .nrst, .in_valid, .in_ready, .in_instr, .rd_addr_n, .rd_addr_m,
    .rd_data_n, .rd_data_m, .gpr_wr, .flag_wr, .branch, .event_block, .illegal_slot);
  gpr_model u_gpr (.sys_clk, .rd_addr_n, .rd_addr_m, .rd_data_n, .rd_data_m, .gpr_wr,
    .pre_we, .pre_addr, .pre_data);
  // idle the request and preload a register through the model's own write port;
  // a pending write-back on the same edge is overridden, not the other way round
  task automatic put(input logic [3:0] idx, input logic [31:0] val);
    @(negedge sys_clk);
    in_valid = 1'b0;
    pre_we = 1'b1;
    pre_addr = idx;
    pre_data = val;
    @(negedge sys_clk);
    pre_we = 1'b0;
  endtask
  // offer one instruction; return just after the edge that takes it
  task automatic send(input logic [15:0] op, input logic [31:0] pc, input logic ob);
    @(negedge sys_clk);
    in_valid = 1'b1;
    in_instr = '{opcode: op, pc: pc, other_branch: ob};
    while (in_ready !== 1'b1) @(negedge sys_clk);
    @(posedge sys_clk);
    #1;
  endtask
  // count down from one, from zero (wraps) and from a plain value
  task automatic t_dt();
    logic [31:0] v [3] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_0100};
    for (int i = 0; i < 3; i++) begin
      put(4'h5, v[i]);
      send(16'h4510, 32'h0, 1'b0);
      `CHK({gpr_wr.we, gpr_wr.addr, gpr_wr.data}, {1'b1, 4'h5, v[i] - 32'h1})
      `CHK(flag_wr, {1'b1, v[i] == 32'h1})
    end
  endtask
  // all four extensions back to back, one result per cycle
  task automatic t_ext();
    logic [3:0] mn [4] = '{MIN_SXB, MIN_SXW, MIN_ZXB, MIN_ZXW};
    logic [31:0] ex [4] = '{32'hffff_ff80, 32'hffff_8080, 32'h0000_0080, 32'h0000_8080};
    put(4'h2, 32'h1234_8080);
    for (int i = 0; i < 4; i++) begin
      send({GRP_MOVE, 4'h1, 4'h2, mn[i]}, 32'h0, 1'b0);
      `CHK({gpr_wr.we, gpr_wr.addr, gpr_wr.data}, {1'b1, 4'h1, ex[i]})
      `CHK(flag_wr.we, 1'b0)
    end
  endtask
  // branch whose slot overwrites the target register; ob marks a branch in the slot
  task automatic t_br(input logic [7:0] low, input logic ob);
    put(4'h3, 32'h0000_1000);
    send({GRP_SYS, 4'h3, low}, 32'h0000_0100, 1'b0);
    `CHK({in_ready, event_block}, 2'b01)
    `CHK(branch.link_we, low == LOW_CALL)
    if (low == LOW_CALL) `CHK(branch.link_data, 32'h0000_0104)
    send({GRP_MOVE, 4'h3, 4'h2, MIN_ZXB}, 32'h0000_0102, ob);
    `CHK({branch.taken, branch.target}, {1'b1, 32'h0000_1000})
    `CHK({illegal_slot, gpr_wr.we, event_block}, {ob, !ob, 1'b0})
  endtask
  // reset while a call waits for its slot: hold-off and pulses clear, no stale redirect
  task automatic t_rst();
    put(4'h3, 32'h0000_2000);
    send({GRP_SYS, 4'h3, LOW_CALL}, 32'h0000_0200, 1'b0);
    @(negedge sys_clk);
    in_valid = 1'b0;
    nrst = 1'b0;
    #1;
    `CHK({in_ready, event_block, illegal_slot}, 3'b100)
    `CHK({branch, gpr_wr, flag_wr}, '0)
    @(negedge sys_clk);
    nrst = 1'b1;
    send({GRP_MOVE, 4'h1, 4'h3, MIN_SXW}, 32'h0000_0300, 1'b0);
    `CHK({gpr_wr.we, gpr_wr.data, branch.taken}, {1'b1, 32'h0000_2000, 1'b0})
  endtask
  // verdict and end of run
  task automatic close_out();
    $display("mismatches %0d of %0d checks", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // main sequence after ten reset cycles
  initial begin
    repeat (10) @(negedge sys_clk);
    nrst = 1'b1;
    t_dt();
    t_ext();
    t_br(LOW_JUMP, 1'b0);
    t_br(LOW_CALL, 1'b0);
    t_br(LOW_JUMP, 1'b1);
    t_rst();
    put(4'h0, 32'h0);
    close_out();
  end
  // hang guard, far above the few dozen cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      close_out();
    end
  end
endmodule
